// [hdl/fsw_flash_regs.sv]
`timescale 1ns/1ps
`default_nettype none

// Function
// - Opcode 06 sets write-enable latch
// - Opcode 04 clears write-enable latch
// - Latch cleared at reset and op completion
// - Latch low refuses timed writes, programs, erases
// - Opcode 50 arms next status write volatile
// - Opcode 05 shifts status out, always
// - Status: busy, latch, protect, protect-lock
// - Busy high while any write runs
// - Protect bits block erases in region
// - Protect bits change only unlocked
// - Chip erase only with nothing protected
// - Lock bit with low pin freezes status
// - Status write rejected when hardware-locked
// - Opcode 15 shifts config out, always
// - Config bit 7 picks 4/8 dummies
// - Status write ends after one byte
// - Timed write sets busy, clears latch
// - Opcode 11 timed config write
// - Writes rejected off byte boundary
// - Sample rising, drive falling clock
module fsw_flash_regs
   import fsw_pkg::*;
#(
   parameter int REG_WRITE_CYCLES = REG_WRITE_TIME_NS / CLK_PERIOD_NS
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic csN,
   input wire logic sclk,
   input wire logic mosi,
   input wire logic wpN,
   input wire logic arrayBusy,
   input wire logic arrayDone,
   output logic miso,
   output logic misoOeN,
   output logic arrayGo,
   output logic [7:0] arrayOp,
   output logic [23:0] arrayAddr,
   output logic [3:0] dualDummyCycles
);

   fsw_spi_if link ();

   logic status_protect_bit;
   logic [4:0] bp;
   logic write_enable_latch;
   logic cfgDc;
   logic volArm;
   logic rstArm;
   fsw_wr_e wrState;
   logic [31:0] wrCount;
   logic pendIsCfg;
   logic [7:0] pendByte;
   logic [7:0] opcode;
   logic [7:0] dataByte;
   logic [23:0] addr;
   logic reading;
   logic [7:0] txShift;
   logic busy;
   logic hwProt;
   logic endOk;
   logic nvDone;
   logic [7:0] statusByte;
   logic [7:0] configByte;
   logic doSetWel, doClrWel, doVol, doStatusVol, doTimed, doArray, doReset;

   fsw_spi_front u_front (
      .clk(clk),
      .reset_n(reset_n),
      .csN(csN),
      .sclk(sclk),
      .mosi(mosi),
      .wpN(wpN),
      .link(link)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Size of the protected region selected by the five protect bits.
   function automatic logic [18:0] protSize(input logic [4:0] b);
      logic [18:0] s;
      s = SIZE_NONE;
      if (!b[4])
      begin
         unique case (b[1:0])
            2'h0: s = SIZE_NONE;
            2'h1: s = SIZE_64K;
            2'h2: s = SIZE_128K;
            2'h3: s = SIZE_ALL;
         endcase
      end
      else
      begin
         unique case (b[2:0])
            3'h0: s = SIZE_NONE;
            3'h1: s = SIZE_4K;
            3'h2: s = SIZE_8K;
            3'h3: s = SIZE_16K;
            3'h7: s = SIZE_ALL;
            default: s = SIZE_32K;
         endcase
      end
      return s;
   endfunction : protSize

   // Whether an array address falls in the protected region; bit 3 picks the low end.
   function automatic logic protHit(input logic [4:0] b, input logic [17:0] a);
      logic [18:0] s;
      s = protSize(b);
      if (s == SIZE_NONE)
      begin
         return 1'b0;
      end
      if (b[3])
      begin
         return {1'b0, a} < s;
      end
      return {1'b0, a} >= (SIZE_ALL - s);
   endfunction : protHit

   ////////////////////////////////////////////////////////////////////////////
   // Readable register images and protection state.
   assign busy = (wrState == WR_TIMING) | arrayBusy;
   assign statusByte = {status_protect_bit, bp, write_enable_latch, busy};
   assign configByte = {cfgDc, 7'h00};
   assign hwProt = status_protect_bit & ~link.wpHigh;
   assign endOk = link.frameEnd & link.atBoundary;
   assign nvDone = (wrState == WR_TIMING) && (wrCount == 32'(REG_WRITE_CYCLES - 1));

   // Decisions taken at a clean end of frame.
   always_comb
   begin
      doSetWel = 1'b0;
      doClrWel = 1'b0;
      doVol = 1'b0;
      doStatusVol = 1'b0;
      doTimed = 1'b0;
      doArray = 1'b0;
      doReset = 1'b0;
      if (endOk && !busy)
      begin
         unique case (opcode)
            OP_SET_WEL: doSetWel = (link.byteNum == LEN_OPCODE);
            OP_CLR_WEL: doClrWel = (link.byteNum == LEN_OPCODE);
            OP_VOL_EN: doVol = (link.byteNum == LEN_OPCODE);
            OP_WR_STATUS:
            begin
               // A volatile write needs no latch; a timed one consumes it.
               doStatusVol = (link.byteNum == LEN_DATA) && volArm && !hwProt;
               doTimed = (link.byteNum == LEN_DATA) && !volArm && write_enable_latch && !hwProt;
            end
            OP_WR_CONFIG: doTimed = (link.byteNum == LEN_DATA) && write_enable_latch;
            OP_PAGE_PROG: doArray = (link.byteNum >= LEN_PROG_MIN) && write_enable_latch && !protHit(bp, addr[17:0]);
            OP_PAGE_ERASE, OP_SECTOR_ERASE, OP_HALF_BLOCK_ERASE, OP_BLOCK_ERASE:
               doArray = (link.byteNum == LEN_ADDR) && write_enable_latch && !protHit(bp, addr[17:0]);
            OP_CHIP_ERASE_A, OP_CHIP_ERASE_B:
               doArray = (link.byteNum == LEN_OPCODE) && write_enable_latch && (protSize(bp) == SIZE_NONE);
            OP_RESET: doReset = (link.byteNum == LEN_OPCODE) && rstArm;
            default: doArray = 1'b0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Opcode, address and data capture as bytes arrive.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         opcode <= 8'h00;
         dataByte <= 8'h00;
         addr <= 24'h000000;
      end
      else if (link.byteDone)
      begin
         if (link.byteNum == 3'h0)
         begin
            opcode <= link.rxByte;
         end
         if (link.byteNum == 3'h1)
         begin
            dataByte <= link.rxByte;
         end
         if (link.byteNum != 3'h0 && link.byteNum < LEN_ADDR)
         begin
            addr <= {addr[15:0], link.rxByte};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // One-shot arming by the volatile-enable and reset-enable commands.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         volArm <= 1'b0;
         rstArm <= 1'b0;
      end
      else if (link.frameEnd)
      begin
         volArm <= doVol;
         rstArm <= endOk && (opcode == OP_RESET_EN) && (link.byteNum == LEN_OPCODE);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write-enable latch; a set in the same cycle as a clear wins.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         write_enable_latch <= 1'b0;
      end
      else if (doSetWel)
      begin
         write_enable_latch <= 1'b1;
      end
      else if (doClrWel || nvDone || arrayDone || doReset)
      begin
         write_enable_latch <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Self-timed register write: busy for the full write time, then commit.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wrState <= WR_IDLE;
         wrCount <= 32'h00000000;
         pendIsCfg <= 1'b0;
         pendByte <= 8'h00;
      end
      else
      begin
         unique case (wrState)
            WR_IDLE:
            begin
               wrCount <= 32'h00000000;
               if (doTimed)
               begin
                  wrState <= WR_TIMING;
                  pendIsCfg <= (opcode == OP_WR_CONFIG);
                  pendByte <= dataByte;
               end
            end
            WR_TIMING:
            begin
               wrCount <= wrCount + 32'h00000001;
               if (nvDone)
               begin
                  wrState <= WR_IDLE;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status protect fields: volatile writes land at once, timed ones at completion.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         status_protect_bit <= SRP_RESET;
         bp <= BP_RESET;
         cfgDc <= DC_RESET;
      end
      else if (doStatusVol)
      begin
         status_protect_bit <= dataByte[ST_SRP];
         bp <= dataByte[ST_BP_HI:ST_BP_LO];
      end
      else if (nvDone)
      begin
         if (pendIsCfg)
         begin
            cfgDc <= pendByte[CFG_DC];
         end
         else
         begin
            status_protect_bit <= pendByte[ST_SRP];
            bp <= pendByte[ST_BP_HI:ST_BP_LO];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register read-out: load on each byte boundary, shift on falling clock.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         reading <= 1'b0;
         txShift <= 8'h00;
         miso <= 1'b0;
         misoOeN <= 1'b1;
      end
      else
      begin
         if (link.frameStart || link.frameEnd)
         begin
            reading <= 1'b0;
            misoOeN <= 1'b1;
         end
         else if (link.byteDone && link.byteNum == 3'h0)
         begin
            // Reads are taken even while a write cycle runs.
            reading <= (link.rxByte == OP_RD_STATUS) || (link.rxByte == OP_RD_CONFIG);
            misoOeN <= !((link.rxByte == OP_RD_STATUS) || (link.rxByte == OP_RD_CONFIG));
            txShift <= (link.rxByte == OP_RD_STATUS) ? statusByte : configByte;
         end
         else if (link.byteDone && reading)
         begin
            txShift <= (opcode == OP_RD_STATUS) ? statusByte : configByte;
         end
         else if (link.sclkFall && reading)
         begin
            miso <= txShift[7];
            txShift <= {txShift[6:0], 1'b0};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Hand-off to the array engine and the dual read dummy count.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         arrayGo <= 1'b0;
         arrayOp <= 8'h00;
         arrayAddr <= 24'h000000;
         dualDummyCycles <= DUMMY_SHORT;
      end
      else
      begin
         arrayGo <= doArray;
         if (doArray)
         begin
            arrayOp <= opcode;
            arrayAddr <= addr;
         end
         dualDummyCycles <= cfgDc ? DUMMY_LONG : DUMMY_SHORT;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks on the register behaviour.
   int busyLen;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         busyLen <= 0;
      end
      else
      begin
         busyLen <= (wrState == WR_TIMING) ? busyLen + 1 : 0;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_set_latch: assert property (endOk && !busy && opcode == OP_SET_WEL && link.byteNum == LEN_OPCODE |=> write_enable_latch)
      else $error("latch not set by enable command");
   a_clear_latch: assert property (endOk && !busy && opcode == OP_CLR_WEL && link.byteNum == LEN_OPCODE |=> !write_enable_latch)
      else $error("latch not cleared by disable command");
   a_no_latch_refuse: assert property (link.frameEnd && !write_enable_latch && !volArm |=> wrState == WR_IDLE && !arrayGo)
      else $error("write accepted without latch");
   a_write_time: assert property ($fell(wrState == WR_TIMING) |-> busyLen == REG_WRITE_CYCLES && !write_enable_latch)
      else $error("register write time or latch wrong");
   a_hw_lock: assert property (link.frameEnd && opcode == OP_WR_STATUS && hwProt |=> $stable(bp) [*2])
      else $error("status changed while hardware locked");
   a_chip_guard: assert property (arrayGo && (arrayOp == OP_CHIP_ERASE_A || arrayOp == OP_CHIP_ERASE_B) |-> bp == 5'h00)
      else $error("chip erase passed with protection set");
   a_vol_instant: assert property (doStatusVol |=> bp == $past(dataByte[ST_BP_HI:ST_BP_LO]) && wrState == WR_IDLE)
      else $error("volatile write not immediate");
   a_off_boundary: assert property (link.frameEnd && !link.atBoundary && !arrayDone && !nvDone |=> $stable(write_enable_latch) && !arrayGo)
      else $error("command acted off byte boundary");
   a_busy_bit: assert property ($rose(wrState == WR_TIMING) |-> statusByte[ST_BUSY] ##1 statusByte[ST_BUSY])
      else $error("busy flag low during write");
   a_dummy_sel: assert property (cfgDc |-> ##1 dualDummyCycles == DUMMY_LONG)
      else $error("dummy count wrong");

   c_set_latch: cover property (doSetWel);
   c_timed_write: cover property ($fell(wrState == WR_TIMING));
   c_status_read: cover property (reading && link.sclkFall);
   c_vol_write: cover property (doStatusVol);

endmodule : fsw_flash_regs

`default_nettype wire

// [hdl/fsw_pkg.sv]
package fsw_pkg;

   // Command codes carried in the first byte of a frame.
   localparam logic [7:0] OP_SET_WEL = 8'h06;
   localparam logic [7:0] OP_CLR_WEL = 8'h04;
   localparam logic [7:0] OP_VOL_EN = 8'h50;
   localparam logic [7:0] OP_RD_STATUS = 8'h05;
   localparam logic [7:0] OP_RD_CONFIG = 8'h15;
   localparam logic [7:0] OP_WR_STATUS = 8'h01;
   localparam logic [7:0] OP_WR_CONFIG = 8'h11;
   localparam logic [7:0] OP_PAGE_PROG = 8'h02;
   localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
   localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
   localparam logic [7:0] OP_HALF_BLOCK_ERASE = 8'h52;
   localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
   localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
   localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;
   localparam logic [7:0] OP_RESET_EN = 8'h66;
   localparam logic [7:0] OP_RESET = 8'h99;

   // Field positions of the status and configuration bytes.
   localparam int ST_BUSY = 0;
   localparam int ST_WEL = 1;
   localparam int ST_BP_LO = 2;
   localparam int ST_BP_HI = 6;
   localparam int ST_SRP = 7;
   localparam int CFG_DC = 7;

   // Values after reset.
   localparam logic [4:0] BP_RESET = 5'h00;
   localparam logic SRP_RESET = 1'b0;
   localparam logic DC_RESET = 1'b0;

   // Dual read dummy clock counts selected by the config bit.
   localparam logic [3:0] DUMMY_SHORT = 4'h4;
   localparam logic [3:0] DUMMY_LONG = 4'h8;

   // Whole bytes in a frame for each command shape.
   localparam logic [2:0] LEN_OPCODE = 3'h1;
   localparam logic [2:0] LEN_DATA = 3'h2;
   localparam logic [2:0] LEN_ADDR = 3'h4;
   localparam logic [2:0] LEN_PROG_MIN = 3'h5;
   localparam logic [2:0] BYTE_NUM_MAX = 3'h7;

   // Register write cycle time and the clock period it is counted in.
   localparam int REG_WRITE_TIME_NS = 5000000;
   localparam int CLK_PERIOD_NS = 5;

   // Protected region sizes over an 18-bit array address.
   localparam logic [18:0] SIZE_NONE = 19'h00000;
   localparam logic [18:0] SIZE_4K = 19'h01000;
   localparam logic [18:0] SIZE_8K = 19'h02000;
   localparam logic [18:0] SIZE_16K = 19'h04000;
   localparam logic [18:0] SIZE_32K = 19'h08000;
   localparam logic [18:0] SIZE_64K = 19'h10000;
   localparam logic [18:0] SIZE_128K = 19'h20000;
   localparam logic [18:0] SIZE_ALL = 19'h40000;

   // Register write cycle sequencer.
   typedef enum logic {
      WR_IDLE = 1'b0,
      WR_TIMING = 1'b1
   } fsw_wr_e;

endpackage : fsw_pkg

// [hdl/fsw_spi_if.sv]
`timescale 1ns/1ps
`default_nettype none

// Byte-level view of the serial link, passed from the front end to the core.
interface fsw_spi_if;
   logic frameStart;
   logic frameEnd;
   logic byteDone;
   logic [7:0] rxByte;
   logic [2:0] byteNum;
   logic atBoundary;
   logic sclkFall;
   logic wpHigh;
   modport front (output frameStart, frameEnd, byteDone, rxByte, byteNum, atBoundary, sclkFall, wpHigh);
   modport core (input frameStart, frameEnd, byteDone, rxByte, byteNum, atBoundary, sclkFall, wpHigh);
endinterface : fsw_spi_if

`default_nettype wire

// [hdl/fsw_spi_front.sv]
`timescale 1ns/1ps
`default_nettype none

module fsw_spi_front
   import fsw_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic csN,
   input wire logic sclk,
   input wire logic mosi,
   input wire logic wpN,
   fsw_spi_if.front link
);

   logic csS1, csS2, csS3;
   logic sclkS1, sclkS2, sclkS3;
   logic mosiS1, mosiS2;
   logic wpS1, wpS2;
   logic [2:0] bitCnt;
   logic [6:0] shiftReg;
   logic sclkRise;

   ////////////////////////////////////////////////////////////////////////////
   // Two-stage synchronisers; the third stage of clock and select feeds edge detection.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         csS1 <= 1'b1;
         csS2 <= 1'b1;
         csS3 <= 1'b1;
         sclkS1 <= 1'b0;
         sclkS2 <= 1'b0;
         sclkS3 <= 1'b0;
         mosiS1 <= 1'b0;
         mosiS2 <= 1'b0;
         wpS1 <= 1'b0;
         wpS2 <= 1'b0;
      end
      else
      begin
         csS1 <= csN;
         csS2 <= csS1;
         csS3 <= csS2;
         sclkS1 <= sclk;
         sclkS2 <= sclkS1;
         sclkS3 <= sclkS2;
         mosiS1 <= mosi;
         mosiS2 <= mosiS1;
         wpS1 <= wpN;
         wpS2 <= wpS1;
      end
   end

   // Input bits are taken on the rising serial clock while selected.
   assign sclkRise = sclkS2 & ~sclkS3 & ~csS2;
   assign link.atBoundary = (bitCnt == 3'h0);

   ////////////////////////////////////////////////////////////////////////////
   // Frame edges and the falling-clock strobe, one cycle each.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         link.frameStart <= 1'b0;
         link.frameEnd <= 1'b0;
         link.sclkFall <= 1'b0;
         link.wpHigh <= 1'b0;
      end
      else
      begin
         link.frameStart <= csS3 & ~csS2;
         link.frameEnd <= ~csS3 & csS2;
         link.sclkFall <= ~sclkS2 & sclkS3 & ~csS2;
         link.wpHigh <= wpS2;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bit and byte assembly, most significant bit first.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         bitCnt <= 3'h0;
         shiftReg <= 7'h00;
         link.byteDone <= 1'b0;
         link.rxByte <= 8'h00;
         link.byteNum <= 3'h0;
      end
      else
      begin
         link.byteDone <= 1'b0;
         if (csS3 & ~csS2)
         begin
            bitCnt <= 3'h0;
            link.byteNum <= 3'h0;
         end
         else if (sclkRise)
         begin
            bitCnt <= bitCnt + 3'h1;
            shiftReg <= {shiftReg[5:0], mosiS2};
            if (bitCnt == 3'h7)
            begin
               link.byteDone <= 1'b1;
               link.rxByte <= {shiftReg, mosiS2};
            end
         end
         if (link.byteDone && link.byteNum != BYTE_NUM_MAX)
         begin
            link.byteNum <= link.byteNum + 3'h1;
         end
      end
   end

endmodule : fsw_spi_front

`default_nettype wire

// [tb/fsw_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

// Host side of the serial link in mode 0; its clock stands still between frames.
module fsw_host_model
(
   output logic csN,
   output logic sclk,
   output logic mosi,
   input wire logic miso
);

   // Idle link: deselected, clock low.
   initial
   begin
      csN = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sends nBits of tx from the top, then clocks rdBits and gathers them into rx.
   task automatic frame(input logic [31:0] tx, input int nBits, input int rdBits, output logic [7:0] rx);
      rx = 8'h00;
      csN = 1'b0;
      for (int i = 0; i < nBits; i++)
      begin
         mosi = tx[31 - i];
         #24 sclk = 1'b1;
         #24 sclk = 1'b0;
      end
      for (int i = 0; i < rdBits; i++)
      begin
         #24 sclk = 1'b1;
         #20 rx = {rx[6:0], miso};
         #4 sclk = 1'b0;
      end
      #24 csN = 1'b1;
      mosi = ~mosi; // A released line shows the inverse of its last value.
      #40;
   endtask : frame

endmodule : fsw_host_model

`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

// Self-checking bench for the write-enable and register block.
module tb_top;
   import fsw_pkg::*;

   localparam int WR_CYC = 400;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic wpN = 1'b1;
   logic arrayBusy = 1'b0;
   logic arrayDone = 1'b0;
   logic csN;
   logic sclk;
   logic mosi;
   logic miso;
   logic misoOeN;
   logic arrayGo;
   logic [7:0] arrayOp;
   logic [23:0] arrayAddr;
   logic [3:0] dualDummyCycles;
   logic [7:0] rx;
   logic [7:0] d;
   int numErrors = 0;
   int compares = 0;
   int goCount = 0;
   int oeLow = 0;
   int busyLeft = 0;
   int seed = 32'h169dafdb;

   fsw_flash_regs #(.REG_WRITE_CYCLES(WR_CYC)) u_dut (.clk(clk), .reset_n(reset_n), .csN(csN), .sclk(sclk),
      .mosi(mosi), .wpN(wpN), .arrayBusy(arrayBusy), .arrayDone(arrayDone), .miso(miso), .misoOeN(misoOeN),
      .arrayGo(arrayGo), .arrayOp(arrayOp), .arrayAddr(arrayAddr), .dualDummyCycles(dualDummyCycles));

   fsw_host_model u_host (.csN(csN), .sclk(sclk), .mosi(mosi), .miso(miso));

   // Free-running 200 MHz clock.
   initial
   begin
      forever #2.5 clk = ~clk;
   end

   // Counts cycles in which the device drives its serial output.
   always @(posedge clk)
   begin
      if (misoOeN === 1'b0)
         oeLow <= oeLow + 1;
   end

   // Array engine stand-in: busy for ten cycles after each accepted command, then a done pulse.
   always @(posedge clk)
   begin
      arrayDone <= 1'b0;
      if (arrayGo === 1'b1)
      begin
         goCount <= goCount + 1;
         busyLeft <= 10;
         arrayBusy <= 1'b1;
      end
      else if (busyLeft == 1)
      begin
         busyLeft <= 0;
         arrayBusy <= 1'b0;
         arrayDone <= 1'b1;
      end
      else if (busyLeft != 0)
         busyLeft <= busyLeft - 1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Expected status byte built from its fields.
   function automatic logic [7:0] expSt(input logic status_protect_bit, input logic [4:0] bp, input logic write_enable_latch, input logic busy);
      return {status_protect_bit, bp, write_enable_latch, busy};
   endfunction : expSt

   // Compares one value and reports a mismatch.
   task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
      compares++;
      if (got !== exp)
      begin
         numErrors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // Prints the counts and the verdict, then ends the run.
   task automatic testDone;
      $display("Comparisons %0d, mismatches %0d", compares, numErrors);
      if (numErrors == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : testDone

   // A write-only frame of nBits, and a one-byte read frame.
   task automatic send(input logic [31:0] tx, input int nBits);
      u_host.frame(tx, nBits, 0, rx);
   endtask : send

   task automatic rd(input logic [7:0] op);
      u_host.frame({op, 24'h000000}, 8, 8, rx);
   endtask : rd

   // Polls status until the busy bit drops, within a bounded number of reads.
   task automatic waitIdle;
      for (int i = 0; i < 12; i++)
      begin
         rd(OP_RD_STATUS);
         if (rx[ST_BUSY] === 1'b0)
            return;
      end
      numErrors++;
      $display("[FAIL] busy wait expected 0 seen 1");
      testDone;
   endtask : waitIdle

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial
   begin
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      check("misoOeN", 24'h1, misoOeN);
      check("dualDummyCycles", DUMMY_SHORT, dualDummyCycles);
      rd(OP_RD_STATUS);
      check("status", expSt(0, 0, 0, 0), rx);
      rd(OP_RD_CONFIG);
      check("config", 8'h00, rx);
      send({OP_SET_WEL, 24'h0}, 8);
      rd(OP_RD_STATUS);
      check("status", expSt(0, 0, 1, 0), rx);
      send({OP_CLR_WEL, 24'h0}, 8);
      rd(OP_RD_STATUS);
      check("status", expSt(0, 0, 0, 0), rx);
      send({OP_WR_STATUS, 8'h0C, 16'h0}, 16);
      rd(OP_RD_STATUS);
      check("status", expSt(0, 0, 0, 0), rx);
      send({OP_SET_WEL, 24'h0}, 8);
      send({OP_WR_STATUS, 8'h0C, 16'h0}, 15);
      send({OP_CLR_WEL, 24'h0}, 12);
      rd(OP_RD_STATUS);
      check("status", expSt(0, 0, 1, 0), rx);
      d = 8'($random(seed)) & 8'h7C;
      send({OP_WR_STATUS, d, 16'h0}, 16);
      rd(OP_RD_STATUS);
      check("status", expSt(0, 0, 1, 1), rx);
      waitIdle;
      check("status", expSt(0, d[6:2], 0, 0), rx);
      for (int i = 0; i < 3; i++)
      begin
         d = 8'($random(seed)) & 8'h7C;
         send({OP_VOL_EN, 24'h0}, 8);
         send({OP_WR_STATUS, d, 16'h0}, 16);
         rd(OP_RD_STATUS);
         check("status", expSt(0, d[6:2], 0, 0), rx);
      end
      send({OP_VOL_EN, 24'h0}, 8);
      send({OP_WR_STATUS, 8'h80, 16'h0}, 16);
      @(posedge clk) wpN <= 1'b0;
      send({OP_SET_WEL, 24'h0}, 8);
      send({OP_WR_STATUS, 8'h00, 16'h0}, 16);
      rd(OP_RD_STATUS);
      check("status", 8'h80, rx & 8'hFD);
      @(posedge clk) wpN <= 1'b1;
      send({OP_VOL_EN, 24'h0}, 8);
      send({OP_WR_STATUS, 8'h00, 16'h0}, 16);
      rd(OP_RD_STATUS);
      check("status", 8'h00, rx & 8'hFC);
      send({OP_SET_WEL, 24'h0}, 8);
      send({OP_WR_CONFIG, 8'h80, 16'h0}, 16);
      waitIdle;
      check("latch", 24'h0, rx[ST_WEL]);
      rd(OP_RD_CONFIG);
      check("config", 8'h80, rx);
      check("dualDummyCycles", DUMMY_LONG, dualDummyCycles);
      send({OP_VOL_EN, 24'h0}, 8);
      send({OP_WR_STATUS, 8'h0C, 16'h0}, 16);
      send({OP_SET_WEL, 24'h0}, 8);
      send({OP_CHIP_ERASE_A, 24'h0}, 8);
      send({OP_SECTOR_ERASE, 24'h001000}, 32);
      check("goCount", 24'h0, 24'(goCount));
      send({OP_VOL_EN, 24'h0}, 8);
      send({OP_WR_STATUS, 8'h00, 16'h0}, 16);
      send({OP_SECTOR_ERASE, 24'h001000}, 32);
      check("arrayAddr", 24'h001000, arrayAddr);
      check("arrayOp", OP_SECTOR_ERASE, arrayOp);
      waitIdle;
      check("latch", 24'h0, rx[ST_WEL]);
      send({OP_SET_WEL, 24'h0}, 8);
      send({OP_CHIP_ERASE_B, 24'h0}, 8);
      waitIdle;
      check("goCount", 24'h2, 24'(goCount));
      check("arrayOp", OP_CHIP_ERASE_B, arrayOp);
      check("oeLowSeen", 24'h1, 24'(oeLow != 0));
      check("misoOeN", 24'h1, misoOeN);
      testDone;
   end

endmodule : tb_top

`default_nettype wire
